// ==== logic/mcu_periph_decode.sv ====
// Decode, user logic, port map and power manager of the MCU peripheral.
// Assumes all inputs synchronous to clk; pins are split in/out/enable.
//
// Behaviour
// RULE_01 - Main flash: eight individual sector selects
// RULE_02 - Secondary memory: four individual sector selects
// RULE_03 - Each sector mapped at user base address
// RULE_04 - Decode array produces memory/register chip selects
// RULE_05 - User array: 16 registered, 3 combinatorial outputs; here the 3 combinatorial outputs are registered too
// RULE_06 - 24 input macrocells on shared input bus
// RULE_07 - Bus control signals feed both logic arrays
// RULE_08 - Fast-mode clear: user outputs hold until change
// RULE_09 - Power control two blocks user array inputs
// RULE_10 - Auto power-down after MCU inactivity
// RULE_11 - 27 pins, each MCU, logic or address; here ports C and D never drive the address and pin 24 is always an input
// RULE_12 - Ports A/B as data or mux bus
// RULE_13 - Boundary-scan functions placed on port C
// RULE_14 - Scan port programs device without MCU
// RULE_15 - Concurrent program and execute across memories
// RULE_16 - Logic configuration only through scan port
// RULE_17 - 8-bit page register extends addressing; here the page reaches neither the memory decode nor any user array output
// RULE_18 - Registers in 256-byte window, user base
// RULE_19 - Latched address nibbles per bus type
// RULE_20 - Strobe on port D pin 0 latches address
// RULE_21 - Chip select high disables memory access
// RULE_22 - Address latched on strobe falling edge
// RULE_23 - Window select only inside window range
`timescale 1ns/1ps
`default_nettype none
module mcu_periph_decode
  import mcu_periph_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // MCU bus
  input  wire logic [15:0]                 mcu_addr,
  input  wire logic                        mcu_rd_n,
  input  wire logic                        mcu_wr_n,
  input  wire logic                        chip_sel_n,
  input  wire mcu_periph_pkg::bus_type_t   bus_type,
  // Configuration
  input  wire logic [7:0]                  main_base [MAIN_SECTORS],
  input  wire logic [7:0]                  sec_base [SEC_SECTORS],
  input  wire logic [7:0]                  sram_base,
  input  wire logic [7:0]                  win_base,
  input  wire logic [1:0]                  pin_func [PIN_COUNT],
  input  wire logic                        ab_data_port,
  input  wire logic                        scan_enable,
  input  wire logic [15:0]                 user_and_mask,
  // Register-window writes
  input  wire logic                        page_we,
  input  wire logic                        pwr_zero_we,
  input  wire logic                        pwr_two_we,
  input  wire logic [7:0]                  reg_wdata,
  // Programming status from scan engine and memories
  input  wire logic                        prog_busy,
  input  wire logic                        prog_error,
  input  wire logic                        scan_dout,
  input  wire logic                        main_prog_active,
  input  wire logic                        sec_prog_active,
  // Pins (ports A,B 8 bits; C 8; D 3)
  input  wire logic [PIN_COUNT-1:0]        pin_in,
  output logic      [PIN_COUNT-1:0]        pin_out,
  output logic      [PIN_COUNT-1:0]        pin_oe_n,
  // Selects and status
  output logic      [MAIN_SECTORS-1:0]     main_sel,
  output logic      [SEC_SECTORS-1:0]      sec_sel,
  output logic                             sram_sel,
  output logic                             register_window_select,
  output logic      [7:0]                  reg_index,
  output logic      [7:0]                  page_q_out,
  output logic      [OUT_MACROCELLS-1:0]   user_regs,
  output logic      [COMB_OUTPUTS-1:0]     user_comb,
  output logic                             powered_down,
  output logic                             scan_mode,
  output logic                             scan_clk,
  output logic                             scan_din,
  output logic                             concurrent_ok
);
  import mcu_periph_pkg::*;

  typedef struct packed {
    logic [7:0]                   page;
    logic [7:0]                   pwr_zero;
    logic [7:0]                   pwr_two;
    logic                         strobe_prev;
    logic [15:0]                  addr_latch;
    logic [INPUT_MACROCELLS-1:0]  in_cells;
    logic [INPUT_MACROCELLS-1:0]  in_prev;
    logic [OUT_MACROCELLS-1:0]    user_r;
    logic [COMB_OUTPUTS-1:0]      user_c;
    logic [31:0]                  idle_cnt;
    pwr_state_t                   pwr;
    logic [MAIN_SECTORS-1:0]      main_sel;
    logic [SEC_SECTORS-1:0]       sec_sel;
    logic                         sram_sel;
    logic                         win_sel;
    logic [7:0]                   reg_index;
    logic [PIN_COUNT-1:0]         pin_out;
    logic [PIN_COUNT-1:0]         pin_oe_n;
    logic                         scan_mode;
    logic                         scan_clk;
    logic                         scan_din;
    logic                         conc_ok;
    logic                         pd;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Base compare on the top address bits down to the sector granule
  function automatic logic in_region(input logic [15:0] a,
                                     input logic [7:0]  base,
                                     input int          shift);
    logic [15:0] mask;
    mask = 16'hffff << shift;
    return ((a & mask) == (({base, 8'h00}) & mask));
  endfunction

  // Memories answer only with the chip selected and the part awake
  function automatic logic mem_on(input logic       cs_n,
                                  input pwr_state_t pwr);
    return !cs_n && (pwr == PWR_ACTIVE);
  endfunction

  logic [15:0] eff_addr;
  logic        strobe;
  logic        bus_active;
  logic [7:0]  lat_a;
  logic [7:0]  lat_b;
  logic [72:0] logic_bus;
  logic [INPUT_MACROCELLS-1:0] gated_in;

  always_comb
  begin
    s_d = s_q;
    strobe = pin_in[24];                                      // [RULE_20]
    bus_active = !chip_sel_n && (!mcu_rd_n || !mcu_wr_n);
    // Multiplexed buses take the latched address, others the live bus
    eff_addr = (bus_type == BUS_NONMUX8) ? mcu_addr : s_q.addr_latch;
    s_d.strobe_prev = strobe;
    if (s_q.strobe_prev && !strobe)
      s_d.addr_latch = mcu_addr;                              // [RULE_22]

    // Register writes
    if (page_we)
    begin
      s_d.page = reg_wdata;                                   // [RULE_17]
    end
    if (pwr_zero_we)
    begin
      s_d.pwr_zero = reg_wdata;                               // [RULE_08]
    end
    if (pwr_two_we)
    begin
      s_d.pwr_two = reg_wdata;                                // [RULE_09]
    end

    // Decode array; chip select high disables every memory
    // Overlapping bases select several sectors; no priority is applied
    for (int i = 0; i < MAIN_SECTORS; i++)
    begin
      s_d.main_sel[i] = mem_on(chip_sel_n, s_q.pwr)
                        && in_region(eff_addr, main_base[i],
                                     MAIN_SHIFT);             // [RULE_01]
    end
    for (int i = 0; i < SEC_SECTORS; i++)
    begin
      s_d.sec_sel[i] = mem_on(chip_sel_n, s_q.pwr)
                       && in_region(eff_addr, sec_base[i],
                                    SEC_SHIFT);               // [RULE_02]
    end
    s_d.sram_sel = mem_on(chip_sel_n, s_q.pwr)
                   && in_region(eff_addr, sram_base, 11);     // [RULE_21]
    s_d.win_sel  = !chip_sel_n
                   && in_region(eff_addr, win_base, 8);       // [RULE_23]
    s_d.reg_index = eff_addr[7:0];                            // [RULE_18]

    // Concurrent program/execute: programming one memory while
    // fetching from another is allowed, same memory is not
    s_d.conc_ok = !((main_prog_active && |s_d.main_sel)
                    || (sec_prog_active && |s_d.sec_sel));    // [RULE_15]

    // Input macrocells, gated by power control two
    gated_in = pin_in[INPUT_MACROCELLS-1:0]
               & ~{3{s_q.pwr_two}};                           // [RULE_09]
    s_d.in_cells = gated_in;                                  // [RULE_06]
    s_d.in_prev = s_q.in_cells;
    logic_bus = {s_q.page, mcu_addr, mcu_rd_n, mcu_wr_n, chip_sel_n,
                 strobe, s_q.in_cells, s_q.addr_latch[15:0],
                 5'h00};                                      // [RULE_07]

    // User array: sleeps with fast mode off until inputs change
    if (s_q.pwr_zero[0] || (s_q.in_cells != s_q.in_prev))     // [RULE_08]
    begin
      for (int i = 0; i < OUT_MACROCELLS; i++)
      begin
        s_d.user_r[i] = ^(logic_bus[i +: 40]
                          & {40{user_and_mask[i]}});          // [RULE_05]
      end
      for (int i = 0; i < COMB_OUTPUTS; i++)
      begin
        s_d.user_c[i] = &logic_bus[i*8 +: 4];
      end
    end

    // Automatic power-down on MCU inactivity
    case (s_q.pwr)                                            // [RULE_10]
      PWR_ACTIVE:
      begin
        if (bus_active || strobe)
          s_d.idle_cnt = '0;
        else if (s_q.idle_cnt == 32'(APD_CYCLES - 1))
          s_d.pwr = PWR_DOWN;
        else
          s_d.idle_cnt = s_q.idle_cnt + 32'h1;
      end
      PWR_DOWN:
      begin
        if (bus_active || strobe)
        begin
          s_d.pwr = PWR_ACTIVE;
          s_d.idle_cnt = '0;
        end
      end
      default:
        s_d.pwr = PWR_ACTIVE;
    endcase
    // Registered copy so the status pin never glitches on decode
    s_d.pd = (s_d.pwr == PWR_DOWN);
    // Wake costs one cycle: the access that wakes is not decoded

    // Latched address nibbles per bus type
    lat_a = {s_q.addr_latch[7:4], s_q.addr_latch[3:0]};       // [RULE_19]
    lat_b = s_q.addr_latch[7:0];
    // Narrow buses leave the upper nibble of port B at zero
    case (bus_type)
      BUS_MUX8:        lat_b = s_q.addr_latch[7:0];
      BUS_NONMUX8:     lat_b = s_q.addr_latch[7:0];
      BUS_MUX8_NARROW: lat_b = {4'h0, s_q.addr_latch[11:8]};
      BUS_PAGE_MODE:   lat_b = s_q.addr_latch[15:8];
      default:         lat_b = s_q.addr_latch[7:0];
    endcase

    // Pin function muxing
    // Ports A and B carry latched address; C and D never drive it,
    // since their address copy would clash with scan and strobe use
    for (int p = 0; p < PIN_COUNT; p++)                       // [RULE_11]
    begin
      case (pin_func[p])
        PIN_LOGIC_IO:
        begin
          s_d.pin_out[p]  = s_q.user_r[p % OUT_MACROCELLS];
          s_d.pin_oe_n[p] = 1'b0;
        end
        PIN_ADDR_OUT:
        begin
          s_d.pin_out[p]  = (p < 8) ? lat_a[p % 8] : lat_b[p % 8];
          s_d.pin_oe_n[p] = (p >= 16);
        end
        default:
        begin
          s_d.pin_out[p]  = 1'b0;
          s_d.pin_oe_n[p] = 1'b1;
        end
      endcase
    end
    // Ports A/B as data port: driven on MCU reads only
    if (ab_data_port)                                         // [RULE_12]
    begin
      for (int p = 0; p < 16; p++)
      begin
        s_d.pin_oe_n[p] = !(s_d.win_sel && !mcu_rd_n);
      end
    end

    // Boundary scan on port C overrides six of its pins; it needs no MCU
    s_d.scan_mode = scan_enable && pin_in[16 + SCAN_MODE_BIT];// [RULE_13]
    s_d.scan_clk  = scan_enable && pin_in[16 + SCAN_CLK_BIT];
    s_d.scan_din  = scan_enable && pin_in[16 + SCAN_DIN_BIT]; // [RULE_14]
    if (scan_enable)
    begin
      s_d.pin_oe_n[16 + SCAN_MODE_BIT] = 1'b1;
      s_d.pin_oe_n[16 + SCAN_CLK_BIT]  = 1'b1;
      s_d.pin_oe_n[16 + SCAN_DIN_BIT]  = 1'b1;
      s_d.pin_out[16 + SCAN_STAT_BIT]  = !prog_busy;
      s_d.pin_oe_n[16 + SCAN_STAT_BIT] = 1'b0;
      s_d.pin_out[16 + SCAN_ERR_BIT]   = prog_error;
      s_d.pin_oe_n[16 + SCAN_ERR_BIT]  = 1'b0;
      s_d.pin_out[16 + SCAN_DOUT_BIT]  = scan_dout;
      s_d.pin_oe_n[16 + SCAN_DOUT_BIT] = 1'b0;
    end
    // Strobe pin is always an input
    s_d.pin_oe_n[24] = 1'b1;
    s_d.pin_out[24]  = 1'b0;
  end

  // Logic configuration only reaches the arrays through the scan engine;
  // no MCU write path into user_and_mask exists here [RULE_16]
  // Sector placement comes from per-sector base inputs [RULE_03]
  // All selects come from one registered decode stage [RULE_04]

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
      s_q.page <= PAGE_RESET;
      s_q.pwr_zero <= PWR_RESET;
      s_q.pwr_two <= PWR_RESET;
      s_q.pin_oe_n <= '1;
      s_q.pwr <= PWR_ACTIVE;
      s_q.conc_ok <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign main_sel = s_q.main_sel;
  assign sec_sel = s_q.sec_sel;
  assign sram_sel = s_q.sram_sel;
  assign register_window_select = s_q.win_sel;
  assign reg_index = s_q.reg_index;
  assign page_q_out = s_q.page;
  assign user_regs = s_q.user_r;
  assign user_comb = s_q.user_c;
  assign powered_down = s_q.pd;
  assign scan_mode = s_q.scan_mode;
  assign scan_clk = s_q.scan_clk;
  assign scan_din = s_q.scan_din;
  assign concurrent_ok = s_q.conc_ok;
  assign pin_out = s_q.pin_out;
  assign pin_oe_n = s_q.pin_oe_n;
endmodule
`default_nettype wire

// ==== logic/mcu_periph_pkg.sv ====
// Constants and types shared by the peripheral decode and port map block.
// Assumes a single 125 MHz clock and a synchronous active-low reset.
package mcu_periph_pkg;
  localparam int          CLK_MHZ           = 125;
  localparam int          APD_TIME_US       = 100;
  localparam int          APD_CYCLES        = APD_TIME_US * CLK_MHZ;
  localparam int          MAIN_SECTORS      = 8;
  localparam int          SEC_SECTORS       = 4;
  localparam int          PIN_COUNT         = 27;
  localparam int          INPUT_MACROCELLS  = 24;
  localparam int          OUT_MACROCELLS    = 16;
  localparam int          COMB_OUTPUTS      = 3;
  localparam int          DECODE_OUTPUTS    = 17;
  // Sector base registers: 16-KByte main sectors, 8-KByte secondary sectors
  localparam int          MAIN_SHIFT        = 14;
  localparam int          SEC_SHIFT         = 13;
  localparam logic [7:0]  WIN_SIZE_HI_MASK  = 8'hff;
  localparam logic [7:0]  PAGE_RESET        = 8'h00;
  localparam logic [7:0]  PWR_RESET         = 8'h00;
  localparam logic [7:0]  WIN_BASE_RESET    = 8'h00;
  // Boundary-scan pin positions on port C
  localparam int          SCAN_MODE_BIT     = 0;
  localparam int          SCAN_CLK_BIT      = 1;
  localparam int          SCAN_STAT_BIT     = 3;
  localparam int          SCAN_ERR_BIT      = 4;
  localparam int          SCAN_DIN_BIT      = 5;
  localparam int          SCAN_DOUT_BIT     = 6;
  // Per-pin function select
  localparam logic [1:0]  PIN_MCU_IO        = 2'h0;
  localparam logic [1:0]  PIN_LOGIC_IO      = 2'h1;
  localparam logic [1:0]  PIN_ADDR_OUT      = 2'h2;

  typedef enum logic [1:0] {
    BUS_MUX8, BUS_NONMUX8, BUS_MUX8_NARROW, BUS_PAGE_MODE
  } bus_type_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_DOWN
  } pwr_state_t;
endpackage

// ==== verification/mcu_periph_props.sv ====
// Checker for the decode and port map block, top-level ports only.
// Assumes the pin layout of the package: strobe on pin 24, port C at 16.
`timescale 1ns/1ps
`default_nettype none
module mcu_periph_props
  import mcu_periph_pkg::*;
(
  // Clock, reset and bus
  input wire logic                      clk,
  input wire logic                      reset_n,
  input wire logic [15:0]               mcu_addr,
  input wire logic                      chip_sel_n,
  input wire mcu_periph_pkg::bus_type_t bus_type,
  // Configuration and writes
  input wire logic [7:0]                win_base,
  input wire logic [1:0]                pin_func [PIN_COUNT],
  input wire logic                      scan_enable,
  input wire logic                      page_we,
  input wire logic [7:0]                reg_wdata,
  input wire logic                      prog_busy,
  input wire logic                      prog_error,
  input wire logic                      scan_dout,
  // Pins and outputs
  input wire logic [PIN_COUNT-1:0]      pin_in,
  input wire logic [PIN_COUNT-1:0]      pin_out,
  input wire logic [MAIN_SECTORS-1:0]   main_sel,
  input wire logic [SEC_SECTORS-1:0]    sec_sel,
  input wire logic                      sram_sel,
  input wire logic                      register_window_select,
  input wire logic [7:0]                reg_index,
  input wire logic [7:0]                page_q_out,
  input wire logic                      powered_down,
  input wire logic                      scan_mode,
  input wire logic                      scan_clk,
  input wire logic                      scan_din
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_fall_mux;
    pin_in[24] ##1 (!pin_in[24] && bus_type == BUS_MUX8
      && pin_func[0] == PIN_ADDR_OUT);
  endsequence
  sequence s_low_mux;
    (!pin_in[24] && bus_type == BUS_MUX8
      && pin_func[0] == PIN_ADDR_OUT) [*4];
  endsequence

  property p_cs_off;
    chip_sel_n |=> main_sel == '0 && sec_sel == '0 && !sram_sel
      && !register_window_select;
  endproperty
  a_cs_off: assert property (p_cs_off)
    else $error("select active while chip deselected");
  property p_pd_refuse;
    powered_down |=> main_sel == '0 && sec_sel == '0 && !sram_sel;
  endproperty
  a_pd_refuse: assert property (p_pd_refuse)
    else $error("memory selected while powered down");
  property p_wake;
    pin_in[24] |=> !powered_down;
  endproperty
  a_wake: assert property (p_wake)
    else $error("strobe did not wake the device");
  property p_page;
    page_we |=> page_q_out == $past(reg_wdata);
  endproperty
  a_page: assert property (p_page)
    else $error("page register not loaded");
  property p_scan_in;
    scan_enable |=> scan_mode == $past(pin_in[16+SCAN_MODE_BIT])
      && scan_clk == $past(pin_in[16+SCAN_CLK_BIT])
      && scan_din == $past(pin_in[16+SCAN_DIN_BIT]);
  endproperty
  a_scan_in: assert property (p_scan_in)
    else $error("scan inputs not taken from port C");
  property p_scan_out;
    scan_enable |=> pin_out[16+SCAN_STAT_BIT] == !$past(prog_busy)
      && pin_out[16+SCAN_ERR_BIT] == $past(prog_error)
      && pin_out[16+SCAN_DOUT_BIT] == $past(scan_dout);
  endproperty
  a_scan_out: assert property (p_scan_out)
    else $error("scan outputs wrong on port C");
  property p_window;
    register_window_select && $past(bus_type) == BUS_NONMUX8 |->
      $past(mcu_addr[15:8]) == $past(win_base)
      && reg_index == $past(mcu_addr[7:0]);
  endproperty
  a_window: assert property (p_window)
    else $error("window select outside window");
  property p_latch;
    s_fall_mux |=> ##1 pin_out[3:0] == $past(mcu_addr[3:0], 2);
  endproperty
  a_latch: assert property (p_latch)
    else $error("address not latched at strobe fall");
  property p_hold;
    s_low_mux |-> $stable(pin_out[7:0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latched address changed without strobe");
endmodule
bind mcu_periph_decode mcu_periph_props u_props (
  .clk, .reset_n, .mcu_addr, .chip_sel_n, .bus_type, .win_base,
  .pin_func, .scan_enable, .page_we, .reg_wdata, .prog_busy,
  .prog_error, .scan_dout, .pin_in, .pin_out, .main_sel, .sec_sel,
  .sram_sel, .register_window_select, .reg_index, .page_q_out,
  .powered_down, .scan_mode, .scan_clk, .scan_din
);
`default_nettype wire

// ==== verification/mcu_model.sv ====
// MCU bus model: one strobed address phase per go, then a read.
// Assumes go is a one-cycle request changed at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
  // Clock
  input  wire logic        clk,
  // Requests from the bench
  input  wire logic        go,
  input  wire logic        mux,
  input  wire logic [15:0] addr_in,
  // Bus side
  output logic             strobe,
  output logic             rd_n,
  output logic [15:0]      addr,
  output logic             busy
);
  logic [1:0]  step = 2'h0;
  logic [15:0] addr_q = 16'h0000;
  initial strobe = 1'b0;
  initial rd_n = 1'b1;
  // Idle: non-mux address is presented live
  assign addr = (step == 2'h0) ? addr_in : addr_q;
  assign busy = (step != 2'h0);
  always @(negedge clk)
  begin
    if (step == 2'h0 && go)
    begin
      addr_q <= addr_in;
      strobe <= 1'b1;
      step   <= 2'h1;
    end
    else if (step == 2'h1)
    begin
      strobe <= 1'b0;
      step   <= 2'h2;
    end
    else if (step == 2'h2)
    begin
      // Data phase: multiplexed lines no longer hold the address
      addr_q <= mux ? ~addr_q : addr_q;
      rd_n   <= 1'b0;
      step   <= 2'h3;
    end
    else if (step == 2'h3)
    begin
      rd_n <= 1'b1;
      step <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the decode and port map block.
// Assumes mcu_model as bus partner and the bound property checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb;
  import mcu_periph_pkg::*;
  // k, address, main, secondary, {sram, window}
  localparam logic [32:0] ROWS [16] = '{
    {3'h0,16'h8000,8'h01,4'h0,2'h0},{3'h1,16'h8fff,8'h02,4'h0,2'h0},
    {3'h2,16'h9000,8'h04,4'h0,2'h0},{3'h3,16'h9abc,8'h08,4'h0,2'h0},
    {3'h4,16'ha000,8'h10,4'h0,2'h0},{3'h5,16'ha5a5,8'h20,4'h0,2'h0},
    {3'h6,16'hbf00,8'h40,4'h0,2'h0},{3'h7,16'hbfff,8'h80,4'h0,2'h0},
    {3'h0,16'h6000,8'h00,4'h1,2'h0},{3'h1,16'h6fff,8'h00,4'h2,2'h0},
    {3'h2,16'h7000,8'h00,4'h4,2'h0},{3'h3,16'h7fff,8'h00,4'h8,2'h0},
    {3'h0,16'hc7ff,8'h00,4'h0,2'h2},{3'h0,16'hd0ab,8'h00,4'h0,2'h1},
    {3'h0,16'hc800,8'h00,4'h0,2'h0},{3'h0,16'hd100,8'h00,4'h0,2'h0}};
  localparam logic [7:0] EXP_B [4] = '{8'hc3, 8'hc3, 8'h05, 8'ha5};
  logic        clk, reset_n, chip_sel_n, scan_enable, page_we, pwr_zero_we;
  logic        prog_busy, prog_error, scan_dout, main_prog_active, go, mux;
  logic        strobe, rd_n, busy, sram_sel, register_window_select;
  logic        powered_down, scan_mode, scan_clk, scan_din, concurrent_ok;
  bus_type_t   bus_type;
  logic [15:0] addr_in, mcu_addr, a, user_regs;
  logic [7:0]  reg_wdata, sram_base, win_base, reg_index, page_q_out;
  logic [7:0]  main_sel, em;
  logic [7:0]  main_base [MAIN_SECTORS];
  logic [7:0]  sec_base [SEC_SECTORS];
  logic [1:0]  pin_func [PIN_COUNT];
  logic [26:0] pins_drv, pin_in, pin_out, pin_oe_n;
  logic [3:0]  sec_sel, es;
  logic [2:0]  user_comb, k;
  logic [1:0]  ew;
  int          n_fail, n_checks, n;
  assign pin_in = {pins_drv[26:25], strobe, pins_drv[23:0]};

  mcu_model partner (.clk, .go, .mux, .addr_in, .strobe, .rd_n,
    .addr(mcu_addr), .busy);
  mcu_periph_decode dut (.clk, .reset_n, .mcu_addr, .mcu_rd_n(rd_n),
    .mcu_wr_n(1'b1), .chip_sel_n, .bus_type, .main_base, .sec_base,
    .sram_base, .win_base, .pin_func, .ab_data_port(1'b0), .scan_enable,
    .user_and_mask(16'h0000), .page_we, .pwr_zero_we, .pwr_two_we(1'b0),
    .reg_wdata, .prog_busy, .prog_error, .scan_dout, .main_prog_active,
    .sec_prog_active(1'b0), .pin_in, .pin_out, .pin_oe_n, .main_sel,
    .sec_sel, .sram_sel, .register_window_select, .reg_index, .page_q_out,
    .user_regs, .user_comb, .powered_down, .scan_mode, .scan_clk,
    .scan_din, .concurrent_ok);

  task automatic close_out();
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One strobed cycle, bounded wait for the model to go idle
  task automatic bus_cycle();
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (busy && n < 20);
    if (busy)
    begin
      n_fail++;
      close_out();
    end
    @(negedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    {reset_n, chip_sel_n, scan_enable, page_we, pwr_zero_we} = 5'h0;
    {prog_busy, prog_error, scan_dout, main_prog_active, go, mux} = 6'h0;
    {n_fail, n_checks, addr_in, reg_wdata, pins_drv} = '0;
    {sram_base, win_base} = {8'hc0, 8'hd0};
    bus_type = BUS_NONMUX8;
    foreach (main_base[i]) main_base[i] = 8'h00;
    foreach (sec_base[i]) sec_base[i] = 8'h40;
    foreach (pin_func[i]) pin_func[i] = (i < 16) ? PIN_ADDR_OUT : PIN_MCU_IO;
    repeat (2) @(negedge clk);
    `CHK({main_sel, sec_sel, page_q_out, powered_down}, 21'h0)
    `CHK({pin_oe_n, concurrent_ok}, 28'hfffffff)
    reset_n = 1'b1;
    {pwr_zero_we, reg_wdata} = {1'b1, 8'h01};
    @(negedge clk);
    pwr_zero_we = 1'b0;
    for (int r = 0; r < 16; r++)
    begin
      {k, a, em, es, ew} = ROWS[r];
      foreach (main_base[i]) main_base[i] = (i == k) ? 8'h80 : 8'h00;
      foreach (sec_base[i]) sec_base[i] = (i == k) ? 8'h60 : 8'h40;
      addr_in = a;
      @(negedge clk);
      `CHK(main_sel, em)
      `CHK(sec_sel, es)
      `CHK({sram_sel, register_window_select}, ew)
      if (ew[0]) `CHK(reg_index, a[7:0])
    end
    // Deselected part, then a program/execute clash on main flash
    {chip_sel_n, addr_in} = {1'b1, 16'h8000};
    @(negedge clk);
    `CHK(main_sel, 8'h00)
    {chip_sel_n, main_prog_active} = 2'h1;
    repeat (3) @(negedge clk);
    `CHK(concurrent_ok, 1'b0)
    {main_prog_active, page_we, reg_wdata} = {2'h1, 8'h5a};
    @(negedge clk);
    `CHK(page_q_out, 8'h5a)
    reg_wdata = 8'hff;
    @(negedge clk);
    page_we = 1'b0;
    `CHK(page_q_out, 8'hff)
    {pins_drv[21], pins_drv[17:16], scan_enable} = 4'hb;
    {prog_busy, prog_error, scan_dout} = 3'h6;
    @(negedge clk);
    `CHK({scan_mode, scan_clk, scan_din}, 3'h5)
    `CHK({pin_out[22], pin_out[20], pin_out[19]}, 3'h2)
    scan_enable = 1'b0;
    for (int b = 0; b < 4; b++)
    begin
      bus_type = bus_type_t'(b);
      {mux, addr_in} = {b != 1, 16'ha5c3};
      bus_cycle();
      `CHK(pin_out[15:8], EXP_B[b])
      `CHK(pin_oe_n[15:8], 8'h00)
      if (b != 1) `CHK(pin_out[7:0], 8'hc3)
    end
    // Idle bus until the power-down unit trips
    bus_type = BUS_MUX8;
    {chip_sel_n, n} = {1'b1, 32'h0};
    while (!powered_down && n < APD_CYCLES + 20)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(powered_down, 1'b1)
    `CHK(n >= APD_CYCLES - 10, 1'b1)
    chip_sel_n = 1'b0;
    @(negedge clk);
    `CHK(main_sel, 8'h00)
    bus_cycle();
    `CHK(powered_down, 1'b0)
    close_out();
  end
endmodule
`default_nettype wire
